// [startup_otp_config_regs.sv]
// start-up configuration register bank with ahb-lite slave and slot sequencer
`default_nettype none
`include "startup_cfg_regs.svh"
// Summary of operation
// RULE_01 - slot 000 never, 001-101 timeslots one-five
// RULE_02 - 110/111 follow hardware enable one/two
// RULE_03 - first word holds three slot fields
// RULE_04 - alive voltage 0.80V plus 50mV steps
// RULE_05 - 100mA limit: normal, soft, battery threshold
// RULE_06 - low battery: trickle charge, hold start-up
// RULE_07 - direction bit and pull field per pin
// RULE_08 - interrupt edge by mode and polarity
// RULE_09 - polarity bit inverts pin when zero
// RULE_10 - bit nine selects open drain
// RULE_11 - enable bit zero tri-states pin
// RULE_12 - input codes 0/1 long/normal debounce
// RULE_13 - input codes 2-7 power and watchdog
// RULE_14 - input codes 8-15 scaling, enables, controls
// RULE_15 - output codes 0-4 basic, 5-7 reserved
// RULE_16 - output codes 8-15 status and clocks
// RULE_17 - clock output source: loop or oscillator
// RULE_18 - crystal inhibit holds on transition
// RULE_19 - second pin word holds clock slot
// RULE_20 - watchdog and charger need security key
// RULE_21 - bit eleven selects pin supply domain
// RULE_22 - slots advance in ascending order
module startup_otp_config_regs #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [2:0]  usb_current_limit,
  input  wire logic        battery_above_threshold,
  input  wire logic        crystal_valid,
  input  wire logic        hw_enable_1,
  input  wire logic        hw_enable_2,
  input  wire logic        fll_clock,
  input  wire logic        osc_32k_clock,
  input  wire logic        ext_clock_2m,
  input  wire logic [7:0]  status_in,
  input  wire logic [1:0]  pin_in,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe,
  output logic [1:0]       pin_pull_up,
  output logic [1:0]       pin_pull_down,
  output logic [1:0]       pin_supply_domain,
  output logic [1:0]       pin_event,
  output logic [15:0]      input_requests,
  output logic             alive_reg_enable,
  output logic [3:0]       alive_reg_voltage_sel,
  output logic             ext_power_en_a,
  output logic             ext_power_en_b,
  output logic             clock_output,
  output logic             clock_output_en,
  output logic             charger_enable,
  output logic             trickle_charge,
  output logic             soft_start,
  output logic             watchdog_enable,
  output logic             on_state
);
  // ==========================================================
  // registers
  logic [15:0] alive_ext_q;
  logic [15:0] pin1_q;
  logic [15:0] pin2_q;
  logic [15:0] ctrl_q;
  logic        key_ok_q;
  logic        wr_pend_q;
  logic [15:0] wr_idx_q;
  logic [15:0] rd_data_d;
  logic [31:0] hrdata_q;
  startup_cfg_pkg::seq_state_t state_q;
  startup_cfg_pkg::seq_state_t state_d;
  logic [2:0]  slot_q;
  logic [31:0] tick_q;
  logic        start_req_q;
  // ==========================================================
  // ahb-lite decode, always zero wait states
  wire logic        access  = hsel & hready & htrans[1];
  wire logic [15:0] a_idx   = haddr[17:2];
  wire logic        wr_word = wr_pend_q;
  wire logic [15:0] wdat    = hwdata[15:0];
  wire logic        wr_alive = wr_word && (wr_idx_q == `IDX_ALIVE_EXT);
  wire logic        wr_pin1  = wr_word && (wr_idx_q == `IDX_PIN1_CFG);
  wire logic        wr_pin2  = wr_word && (wr_idx_q == `IDX_PIN2_CFG);
  wire logic        wr_ctrl  = wr_word && (wr_idx_q == `IDX_CTRL);
  wire logic        wr_key   = wr_word && (wr_idx_q == `IDX_KEY);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  // ==========================================================
  // field views
  wire logic [2:0] alive_slot = alive_ext_q[`ALIVE_SLOT_LSB +: 3]; // RULE_03
  wire logic [2:0] extb_slot  = alive_ext_q[`EXTB_SLOT_LSB +: 3]; // RULE_03
  wire logic [2:0] exta_slot  = alive_ext_q[`EXTA_SLOT_LSB +: 3]; // RULE_03
  wire startup_cfg_pkg::usb_startup_t usb_mode =
    startup_cfg_pkg::usb_startup_t'(alive_ext_q[`USB_MODE_LSB +: 2]);
  wire logic [2:0] clk_slot   = pin2_q[`PIN2_CLKSLOT_LSB +: 3]; // RULE_19
  wire logic       low_usb    = (usb_current_limit == `USB_CURRENT_LIMIT_100MA);
  wire logic       batt_mode  = low_usb & usb_mode[1]; // RULE_05
  wire logic       crystal_startup_inhibit   = pin1_q[`PIN1_XTAL_BIT];
  wire logic       start_cmd  = ctrl_q[0];
  // ==========================================================
  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 16'h0000;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= access & hwrite;
      wr_idx_q  <= a_idx;
      hrdata_q  <= (access & ~hwrite) ? {16'h0000, rd_data_d} : 32'h0000_0000;
    end
  end
  // read mux; unmapped indices read zero
  always_comb begin
    rd_data_d = 16'h0000;
    case (a_idx)
      `IDX_ALIVE_EXT: rd_data_d = alive_ext_q;
      `IDX_PIN1_CFG:  rd_data_d = pin1_q;
      `IDX_PIN2_CFG:  rd_data_d = pin2_q;
      `IDX_CTRL:      rd_data_d = ctrl_q;
      `IDX_STATUS:    rd_data_d = {9'h000, key_ok_q, start_req_q, trickle_charge, on_state, slot_q};
      default:             rd_data_d = 16'h0000;
    endcase
  end
  // ==========================================================
  // configuration words; key-protected bits keep their value without key
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alive_ext_q <= `RST_ALIVE_EXT;
      pin1_q      <= `RST_PIN1_CFG;
      pin2_q      <= `RST_PIN2_CFG;
      ctrl_q      <= `RST_CTRL;
      key_ok_q    <= 1'b0;
    end else begin
      if (wr_alive) begin
        alive_ext_q <= wdat;
      end
      if (wr_pin1) begin
        pin1_q <= {wdat[15:1], key_ok_q ? wdat[`PIN1_CHG_BIT] : pin1_q[`PIN1_CHG_BIT]}; // RULE_20
      end
      if (wr_pin2) begin
        pin2_q <= {wdat[15:1], key_ok_q ? wdat[`PIN2_WDOG_BIT] : pin2_q[`PIN2_WDOG_BIT]}; // RULE_20
      end
      if (wr_ctrl) begin
        ctrl_q <= {15'h0000, wdat[0]};
      end
      if (wr_key) begin
        key_ok_q <= (wdat == `KEY_VALUE); // RULE_20
      end else if (wr_pin1 | wr_pin2) begin
        key_ok_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // start-up sequencer
  wire logic tick_done = (tick_q >= 32'(SLOT_CYCLES - 1));
  always_comb begin
    state_d = state_q;
    case (state_q)
      startup_cfg_pkg::seq_idle: begin
        if (start_req_q) begin
          state_d = startup_cfg_pkg::seq_trickle;
        end
      end
      startup_cfg_pkg::seq_trickle: begin
        // in battery modes at the 100mA limit, hold request in trickle charge until battery is over threshold
        if (!start_req_q) begin
          state_d = startup_cfg_pkg::seq_idle;
        end else if (!batt_mode || battery_above_threshold) begin // RULE_06
          state_d = startup_cfg_pkg::seq_wait_xtal;
        end
      end
      startup_cfg_pkg::seq_wait_xtal: begin
        if (!crystal_startup_inhibit || crystal_valid) begin // RULE_18
          state_d = startup_cfg_pkg::seq_run;
        end
      end
      startup_cfg_pkg::seq_run: begin
        if (tick_done && slot_q == 3'h5) begin
          state_d = startup_cfg_pkg::seq_on;
        end
      end
      startup_cfg_pkg::seq_on: begin
        if (!start_req_q) begin
          state_d = startup_cfg_pkg::seq_idle;
        end
      end
      default: state_d = startup_cfg_pkg::seq_idle;
    endcase
  end
  // state, slot counter and request latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= startup_cfg_pkg::seq_idle;
      slot_q      <= 3'h0;
      tick_q      <= 32'h0000_0000;
      start_req_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      start_req_q <= start_cmd;
      if (state_q != startup_cfg_pkg::seq_run) begin
        tick_q <= 32'h0000_0000;
        slot_q <= (state_q == startup_cfg_pkg::seq_on) ? 3'h5 : 3'h0;
      end else if (slot_q == 3'h0) begin
        slot_q <= 3'h1; // RULE_22
      end else if (tick_done) begin
        tick_q <= 32'h0000_0000;
        slot_q <= (slot_q == 3'h5) ? 3'h5 : slot_q + 3'h1; // RULE_22
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end
  wire logic seq_active = (state_q == startup_cfg_pkg::seq_run) || (state_q == startup_cfg_pkg::seq_on);
  assign on_state       = (state_q == startup_cfg_pkg::seq_on);
  assign trickle_charge = (state_q == startup_cfg_pkg::seq_trickle) & batt_mode & ~battery_above_threshold; // RULE_06
  assign soft_start     = low_usb & (usb_mode == startup_cfg_pkg::startup_soft); // RULE_05
  // ==========================================================
  // enable outputs, one decoder per slot field
  logic [3:0]  en_vec;
  logic [11:0] sel_vec;
  assign sel_vec = {clk_slot, extb_slot, exta_slot, alive_slot};
  for (genvar g = 0; g < 4; g++) begin : g_slot
    slot_decode u_dec (
      .slot_sel   (sel_vec[g*3 +: 3]),
      .slot_done  (slot_q),
      .seq_active (seq_active),
      .hw_enable_a(hw_enable_1),
      .hw_enable_b(hw_enable_2),
      .enable     (en_vec[g])
    );
  end
  assign alive_reg_enable      = en_vec[0];
  assign ext_power_en_a        = en_vec[1];
  assign ext_power_en_b        = en_vec[2];
  assign clock_output_en       = en_vec[3];
  assign alive_reg_voltage_sel = alive_ext_q[`ALIVE_VSEL_LSB +: 4]; // RULE_04
  assign clock_output          = clock_output_en & (pin1_q[`PIN1_CLKSRC_BIT] ? osc_32k_clock : fll_clock); // RULE_17
  assign charger_enable        = pin1_q[`PIN1_CHG_BIT]; // RULE_20
  assign watchdog_enable       = pin2_q[`PIN2_WDOG_BIT]; // RULE_20
  // ==========================================================
  // pin functions: output source table and input request map
  logic [15:0] out_src;
  logic [3:0]  fn    [2];
  logic [1:0]  isin;
  logic [1:0]  level;
  logic [1:0]  outv;
  logic [15:0] req   [2];
  // 0 register value, 1-4 basic, 5-7 reserved low, 8-15 status and clocks
  assign out_src = {status_in[7], ext_clock_2m, status_in[6:5], ext_power_en_b, ext_power_en_a,
                    status_in[1:0], 3'h0, ~start_req_q & on_state, ~on_state & start_req_q,
                    on_state, osc_32k_clock, ctrl_q[0]}; // RULE_15 RULE_16
  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign outv[p] = out_src[fn[p]];
    // one-hot request line per input function; long/short debounce take lines 0 and 1
    assign req[p]  = isin[p] ? (16'(level[p]) << fn[p]) : 16'h0000; // RULE_12 RULE_13 RULE_14
    pin_ctrl u_pin (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .cfg          (p == 0 ? pin1_q : pin2_q),
      .out_value    (outv[p]),
      .pin_in       (pin_in[p]),
      .pin_out      (pin_out[p]),
      .pin_oe       (pin_oe[p]),
      .pull_up_en   (pin_pull_up[p]),
      .pull_down_en (pin_pull_down[p]),
      .supply_domain(pin_supply_domain[p]),
      .pin_level    (level[p]),
      .pin_event    (pin_event[p]),
      .function_sel (fn[p]),
      .is_input     (isin[p])
    );
  end
  assign input_requests = req[0] | req[1];
endmodule // startup_otp_config_regs
`default_nettype wire

// [startup_cfg_regs.svh]
// register offsets, field positions, reset values and timing counts of the start-up configuration bank
`ifndef STARTUP_CFG_REGS_SVH
`define STARTUP_CFG_REGS_SVH
// ==========================================================
// register indices (byte address is four times the index)
`define IDX_ALIVE_EXT      16'h7819
`define IDX_PIN1_CFG       16'h781a
`define IDX_PIN2_CFG       16'h781b
`define IDX_CTRL           16'h7820
`define IDX_STATUS         16'h7821
`define IDX_KEY            16'h7822
// ==========================================================
// first word field positions
`define ALIVE_SLOT_LSB     13
`define ALIVE_VSEL_LSB     8
`define EXTB_SLOT_LSB      5
`define EXTA_SLOT_LSB      2
`define USB_MODE_LSB       0
// ==========================================================
// pin word field positions
`define PIN_DIR_BIT        15
`define PIN_PULL_LSB       13
`define PIN_EDGE_BIT       12
`define PIN_DOM_BIT        11
`define PIN_POL_BIT        10
`define PIN_OD_BIT         9
`define PIN_ENA_BIT        8
`define PIN_FN_LSB         4
`define PIN1_CLKSRC_BIT    3
`define PIN1_XTAL_BIT      1
`define PIN1_CHG_BIT       0
`define PIN2_CLKSLOT_LSB   1
`define PIN2_WDOG_BIT      0
// ==========================================================
// reset values
`define RST_ALIVE_EXT      16'h0000
`define RST_PIN1_CFG       16'ha400
`define RST_PIN2_CFG       16'ha401
`define RST_CTRL           16'h0000
// ==========================================================
// security key, usb 100ma code, slot timing
`define KEY_VALUE          16'h5a5a
`define USB_CURRENT_LIMIT_100MA     3'h2
`define SLOT_TIME_US       1000
`define CLK_MHZ            20
`define SLOT_CYCLES        (`SLOT_TIME_US * `CLK_MHZ)
`endif

// [startup_cfg_pkg.sv]
// types shared by the start-up configuration bank
`default_nettype none
package startup_cfg_pkg;
  typedef enum logic [1:0] {
    startup_normal, startup_soft, startup_batt_a, startup_batt_b
  } usb_startup_t;
  typedef enum logic [1:0] {
    pull_none, pull_down, pull_up, pull_reserved
  } pull_t;
  typedef enum {
    seq_idle, seq_trickle, seq_wait_xtal, seq_run, seq_on
  } seq_state_t;
endpackage : startup_cfg_pkg
`default_nettype wire

// [slot_decode.sv]
// decode of a 3-bit start-up slot selector into an output enable
`default_nettype none
module slot_decode (
  input  wire logic [2:0] slot_sel,
  input  wire logic [2:0] slot_done,
  input  wire logic       seq_active,
  input  wire logic       hw_enable_a,
  input  wire logic       hw_enable_b,
  output logic            enable
);
  // ==========================================================
  // decode
  // 000 never, 001..101 after slot reached, 110/111 hardware enables
  wire logic by_slot = (slot_sel != 3'h0) && (slot_sel <= 3'h5) && seq_active && (slot_done >= slot_sel); // RULE_01
  wire logic by_hw_a = (slot_sel == 3'h6) && hw_enable_a; // RULE_02
  wire logic by_hw_b = (slot_sel == 3'h7) && hw_enable_b; // RULE_02
  assign enable = by_slot | by_hw_a | by_hw_b;
endmodule // slot_decode
`default_nettype wire

// [pin_ctrl.sv]
// per-pin configuration decode: drive, pull, edge detect, input function
`default_nettype none
`include "startup_cfg_regs.svh"
module pin_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] cfg,
  input  wire logic        out_value,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             pull_up_en,
  output logic             pull_down_en,
  output logic             supply_domain,
  output logic             pin_level,
  output logic             pin_event,
  output logic [3:0]       function_sel,
  output logic             is_input
);
  logic prev_q;
  logic drv;
  wire logic dir_in  = cfg[`PIN_DIR_BIT];
  wire logic edge_m  = cfg[`PIN_EDGE_BIT];
  wire logic pol     = cfg[`PIN_POL_BIT];
  wire logic od      = cfg[`PIN_OD_BIT];
  wire logic ena     = cfg[`PIN_ENA_BIT];
  wire startup_cfg_pkg::pull_t pull = startup_cfg_pkg::pull_t'(cfg[`PIN_PULL_LSB +: 2]);
  // ==========================================================
  // output and pad control
  assign drv           = pol ? out_value : ~out_value; // RULE_09
  assign pin_out       = od ? 1'b0 : drv; // RULE_10
  assign pin_oe        = ena & ~dir_in & (od ? ~drv : 1'b1); // RULE_11
  assign pull_up_en    = (pull == startup_cfg_pkg::pull_up); // RULE_07
  assign pull_down_en  = (pull == startup_cfg_pkg::pull_down); // RULE_07
  assign supply_domain = cfg[`PIN_DOM_BIT]; // RULE_21
  assign function_sel  = cfg[`PIN_FN_LSB +: 4];
  assign is_input      = dir_in; // RULE_07
  assign pin_level     = ena & dir_in & (pol ? pin_in : ~pin_in); // RULE_09
  // ==========================================================
  // edge detect on the raw pad level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end
  // single edge follows polarity, both edges when mode is set
  assign pin_event = ena & dir_in & (edge_m ? (pin_in ^ prev_q)
                     : (pol ? (pin_in & ~prev_q) : (~pin_in & prev_q))); // RULE_08
endmodule // pin_ctrl
`default_nettype wire

// [startup_otp_config_regs_properties.sv]
// port-level assertions of the bank and their bind
`default_nettype none
`include "startup_cfg_regs.svh"
module startup_otp_config_regs_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [1:0]  pin_in,
  input wire logic [1:0]  pin_event,
  input wire logic [1:0]  pin_pull_up,
  input wire logic [1:0]  pin_pull_down,
  input wire logic [1:0]  pin_supply_domain,
  input wire logic [3:0]  alive_reg_voltage_sel,
  input wire logic        watchdog_enable,
  input wire logic        charger_enable,
  input wire logic        trickle_charge,
  input wire logic        on_state,
  input wire logic        battery_above_threshold
);
  wire logic        wr_take;
  wire logic [15:0] idx;
  // ==========================================================
  // write address phase
  assign wr_take = hsel & htrans[1] & hwrite;
  assign idx     = haddr[17:2];
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // properties
  AST_EVENT_A_NEEDS_EDGE: assert property (pin_event[0] |-> (pin_in[0] != $past(pin_in[0])))
    else $error("pin a event without an edge");
  AST_EVENT_B_NEEDS_EDGE: assert property (pin_event[1] |-> (pin_in[1] != $past(pin_in[1])))
    else $error("pin b event without an edge");
  AST_WDOG_ONLY_BY_WRITE: assert property ($changed(watchdog_enable) |->
    $past(wr_take, 2) && ($past(idx, 2) == `IDX_PIN2_CFG)) else $error("watchdog moved unwritten");
  AST_CHG_ONLY_BY_WRITE: assert property ($changed(charger_enable) |->
    $past(wr_take, 2) && ($past(idx, 2) == `IDX_PIN1_CFG)) else $error("charger moved unwritten");
  AST_VSEL_ONLY_BY_WRITE: assert property ($changed(alive_reg_voltage_sel) |->
    $past(wr_take, 2) && ($past(idx, 2) == `IDX_ALIVE_EXT)) else $error("vsel moved unwritten");
  AST_DOMAIN_ONLY_BY_WRITE: assert property ($changed(pin_supply_domain) |-> $past(wr_take, 2) &&
    (($past(idx, 2) == `IDX_PIN1_CFG) || ($past(idx, 2) == `IDX_PIN2_CFG))) else $error("domain moved alone");
  AST_PULL_EXCLUSIVE: assert property ((pin_pull_up & pin_pull_down) == 2'h0)
    else $error("pull-up and pull-down both on");
  AST_TRICKLE_EXIT: assert property ($rose(battery_above_threshold) |-> ##[0:3] !trickle_charge)
    else $error("trickle held");
  AST_TRICKLE_NOT_ON: assert property (trickle_charge |-> !on_state)
    else $error("on during trickle");
  // main scenarios
  cover property ($rose(on_state));
  cover property (trickle_charge ##1 !trickle_charge);
  cover property ($fell(watchdog_enable));
endmodule // startup_otp_config_regs_checker
bind startup_otp_config_regs startup_otp_config_regs_checker u_checker (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .pin_in, .pin_event, .pin_pull_up, .pin_pull_down,
  .pin_supply_domain, .alive_reg_voltage_sel, .watchdog_enable, .charger_enable, .trickle_charge,
  .on_state, .battery_above_threshold
);
`default_nettype wire

// [startup_otp_config_regs_tb.sv]
// self-checking bench for the start-up configuration bank
`default_nettype none
`include "startup_cfg_regs.svh"
module startup_otp_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 6;
  // ==========================================================
  // signals
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hresp, hreadyout;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0]  htrans = 2'h0, pin_in = 2'h0, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_supply_domain;
  logic [1:0]  pin_event;
  logic [2:0]  hsize = 3'h0, usb_current_limit = 3'h0;
  logic [7:0]  status_in = 8'h00;
  logic [15:0] input_requests;
  logic [3:0]  alive_reg_voltage_sel;
  logic        battery_above_threshold = 1'b0, crystal_valid = 1'b0, hw_enable_1 = 1'b0, hw_enable_2 = 1'b0;
  logic        fll_clock = 1'b1, osc_32k_clock = 1'b0, ext_clock_2m = 1'b0;
  logic        alive_reg_enable, ext_power_en_a, ext_power_en_b, clock_output, clock_output_en;
  logic        charger_enable, trickle_charge, soft_start, watchdog_enable, on_state;
  wire logic   hready;
  int          failures = 0, compares = 0, cyc = 0;
  // one slave drives ready
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  startup_otp_config_regs #(.SLOT_CYCLES(SC)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .usb_current_limit, .battery_above_threshold, .crystal_valid, .hw_enable_1, .hw_enable_2, .fll_clock,
    .osc_32k_clock, .ext_clock_2m, .status_in, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
    .pin_supply_domain, .pin_event, .input_requests, .alive_reg_enable, .alive_reg_voltage_sel, .ext_power_en_a,
    .ext_power_en_b, .clock_output, .clock_output_en, .charger_enable, .trickle_charge, .soft_start,
    .watchdog_enable, .on_state
  );
  // ==========================================================
  // report and compare
  task automatic test_done();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  // ==========================================================
  // ahb-lite master, phase held until ready
  task automatic wait_ready();
    int   n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin
      $display("ERROR hreadyout expected 1 seen %b", r);
      failures++;
      test_done();
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {14'h0000, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'h0000, wd};
    wait_ready();
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(nm, {16'h0000, exp}, rd);
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  // pin b events after pad goes to v
  task automatic edge_cnt(input logic v, input int exp);
    int c;
    c = 0;
    @(posedge hclk);
    pin_in <= {v, 1'b0};
    repeat (4) begin
      @(negedge hclk);
      c += (pin_event[1] === 1'b1);
    end
    chk("event count", exp, c);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int         t[5];
    int         n;
    logic [5:0] s_tab, oe_tab, out_tab;
    s_tab = 6'h2d;
    oe_tab = 6'h17;
    out_tab = 6'h01;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("word1", `IDX_ALIVE_EXT, 16'h0000);
    rdc("pin1", `IDX_PIN1_CFG, 16'ha400);
    rdc("pin2", `IDX_PIN2_CFG, 16'ha401);
    chk("reset outputs", 32'h0000_0604, {20'h0, hresp, pin_pull_down, pin_pull_up, pin_oe, pin_supply_domain,
      watchdog_enable, charger_enable, alive_reg_enable});
    wr(16'h7818, 16'hffff);
    rdc("unmapped", 16'h7818, 16'h0000);
    $display("test reset done");
    // hardware enable codes
    wr(`IDX_ALIVE_EXT, 16'hcfe0);
    rdc("word1", `IDX_ALIVE_EXT, 16'hcfe0);
    chk("voltage select", 32'h0000_000f, {28'h0, alive_reg_voltage_sel});
    for (int h = 0; h < 4; h++) begin
      @(posedge hclk);
      hw_enable_1 <= h[0];
      hw_enable_2 <= h[1];
      settle();
      chk("hw enables", {29'h0, h[0], h[1], 1'b0}, {29'h0, alive_reg_enable, ext_power_en_b, ext_power_en_a});
    end
    $display("test enables done");
    // key-protected bits
    wr(`IDX_PIN2_CFG, 16'ha400);
    rdc("pin2 no key", `IDX_PIN2_CFG, 16'ha401);
    wr(`IDX_KEY, `KEY_VALUE);
    wr(`IDX_PIN2_CFG, 16'ha400);
    rdc("pin2 keyed", `IDX_PIN2_CFG, 16'ha400);
    chk("watchdog", 32'h0000_0000, {31'h0, watchdog_enable});
    wr(`IDX_PIN1_CFG, 16'ha401);
    rdc("pin1 no key", `IDX_PIN1_CFG, 16'ha400);
    wr(`IDX_KEY, `KEY_VALUE);
    wr(`IDX_PIN1_CFG, 16'ha401);
    settle();
    chk("charger", 32'h0000_0001, {31'h0, charger_enable});
    $display("test key done");
    // pulls and domain
    for (int p = 0; p < 3; p++) begin
      wr(`IDX_PIN2_CFG, 16'h8400 | (p << 13) | ((p & 1) << 11));
      settle();
      chk("pull and domain", {29'h0, p == 2, p == 1, p[0]},
        {29'h0, pin_pull_up[1], pin_pull_down[1], pin_supply_domain[1]});
    end
    $display("test pulls done");
    // pin a drive modes
    for (int i = 0; i < 6; i++) begin
      wr(`IDX_PIN1_CFG, (i == 2) ? 16'h01c0 : (i > 4) ? 16'h04c0 : (i > 2) ? 16'h07c0 : 16'h05c0);
      status_in <= {2'h0, s_tab[i], 5'h00};
      settle();
      chk("pin a drive", {30'h0, oe_tab[i], out_tab[i]}, {30'h0, pin_oe[0], pin_oe[0] & pin_out[0]});
    end
    $display("test drive done");
    // input functions
    @(posedge hclk);
    pin_in <= 2'h2;
    for (int k = 0; k < 16; k++) begin
      wr(`IDX_PIN2_CFG, 16'h8500 | (k << 4));
      settle();
      chk("input request", 32'h0000_0001 << k, {16'h0000, input_requests});
    end
    $display("test inputs done");
    // edge modes
    for (int m = 0; m < 3; m++) begin
      wr(`IDX_PIN2_CFG, (m == 0) ? 16'h8510 : (m == 1) ? 16'h8110 : 16'h9510);
      edge_cnt(1'b0, m > 0);
      edge_cnt(1'b1, m != 1);
    end
    $display("test events done");
    // start-up, low battery, crystal inhibit
    wr(`IDX_ALIVE_EXT, 16'h60a6);
    wr(`IDX_PIN1_CFG, 16'h05c2);
    wr(`IDX_PIN2_CFG, 16'h8514);
    usb_current_limit <= `USB_CURRENT_LIMIT_100MA;
    wr(`IDX_CTRL, 16'h0001);
    settle();
    chk("trickle", 32'h0000_0001, {31'h0, trickle_charge});
    repeat (3 * SC) @(posedge hclk);
    battery_above_threshold <= 1'b1;
    repeat (3 * SC) @(posedge hclk);
    chk("held for crystal", 32'h0000_0000, {27'h0, trickle_charge, alive_reg_enable, ext_power_en_a,
      clock_output_en, on_state});
    crystal_valid <= 1'b1;
    t = '{-1, -1, -1, -1, -1};
    n = 0;
    while (on_state !== 1'b1 && n < 200) begin
      @(negedge hclk);
      if (t[0] < 0 && ext_power_en_a === 1'b1) t[0] = cyc;
      if (t[1] < 0 && clock_output_en === 1'b1) t[1] = cyc;
      if (t[2] < 0 && alive_reg_enable === 1'b1) t[2] = cyc;
      if (t[3] < 0 && ext_power_en_b === 1'b1) t[3] = cyc;
      n++;
    end
    chk("slot 1 to 2", SC, t[1] - t[0]);
    chk("slot 2 to 3", SC, t[2] - t[1]);
    chk("slot 3 to 5", 2 * SC, t[3] - t[2]);
    chk("on reached", 32'h0000_0001, {31'h0, on_state});
    chk("clock from loop", 32'h0000_0001, {31'h0, clock_output});
    wr(`IDX_PIN1_CFG, 16'h05ca);
    settle();
    chk("clock from oscillator", 32'h0000_0000, {31'h0, clock_output});
    wr(`IDX_ALIVE_EXT, 16'h60a5);
    settle();
    chk("soft start", 32'h0000_0001, {31'h0, soft_start});
    usb_current_limit <= 3'h0;
    settle();
    chk("soft start off limit", 32'h0000_0000, {31'h0, soft_start});
    $display("test sequence done");
    test_done();
  end
endmodule // startup_otp_config_regs_tb
`default_nettype wire
